/* trc_pkg.sv */
// Shared constants and types of the terminal run command decoder.
package trc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_TICK_NS = 1000000;
	localparam int MS_TICK_CYC = MS_TICK_NS / CLK_PERIOD_NS;
	localparam int FILT_STEP_MS = 10;
	localparam int DLY_STEP_MS = 100;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [4:0] POL_ONE_RESET = 5'h00;
	localparam logic [2:0] POL_TWO_RESET = 3'h0;
	localparam logic [15:0] DLY_RESET = 16'h0000;
	localparam logic [15:0] DLY_MAX = 16'h8ca0;
	localparam logic [9:0] FILT_RESET = 10'h00a;
	localparam logic [9:0] VOLT_FULL = 10'h3e8;
	localparam logic [1:0] RES_COARSE = 2'h1;
	localparam logic [4:0] RATE_SCALE_COARSE = 5'h0a;
	localparam int FREQ_W = 32;

	typedef enum logic [1:0] {
		MODE_TWO_A = 2'b00,
		MODE_TWO_B = 2'b01,
		MODE_THREE_A = 2'b10,
		MODE_THREE_B = 2'b11
	} trc_mode_e;

	// Volts and current in 0.01 units, settings in 0.01 %, filter time in 0.01 s.
	typedef struct packed {
		logic cur_mode;
		logic [9:0] vmin;
		logic [9:0] vmax;
		logic signed [14:0] smin;
		logic signed [14:0] smax;
		logic signed [14:0] sbelow;
		logic [9:0] ftime;
	} trc_ain_cfg_s;

	typedef struct packed {
		logic [15:0] forward_input;
		logic [15:0] reverse_input;
		logic [15:0] third;
	} trc_dly_cfg_s;
endpackage

/* trc_decoder.sv */
// Terminal run command decoder: input conditioning, run decode, up/down ramp, analog scaling.
//
// Summary of operation
// - Four terminal command modes, default two-wire type one.
// - Two-wire one: lone forward or reverse runs.
// - Two-wire one: both or neither means stop.
// - Two-wire two: forward enables, reverse picks direction.
// - Two-wire two: enable inactive means stop.
// - Three-wire one: third enables, presses start runs.
// - Three-wire: enable inactive stops at once.
// - Three-wire one: latest press decides run state.
// - Three-wire two: forward press starts, reverse picks direction.
// - Three-wire two: reverse inactive forward, active reverse.
// - Up/down ramp at programmable rate, default 1 Hz/s.
// - Rate unit follows the frequency resolution setting.
// - Analog input scaled linearly, clamped at maximum.
// - Below minimum uses the below-minimum setting.
// - Current input: one mA counts as 0.5 V.
// - Analog input filtered with programmable time constant.
// - Second analog input has own identical settings.
// - Forward, reverse, third inputs have change delay.
// - Other inputs take effect without delay.
// - First polarity word covers inputs one to five.
// - Second polarity word covers inputs six to eight.
// - High active: connected to common counts active.
`timescale 1ns/10ps

module trc_delay (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic din,
	input wire logic [15:0] dly,
	output logic dout
);
	logic [15:0] cnt_reg;
	// Counting one tick past the setting keeps the delay at least the programmed time.
	wire logic expired = (dly == 16'h0000) || (cnt_reg > dly);
	always_ff @(posedge clk) begin
		if (rst) begin
			dout <= 1'b0;
			cnt_reg <= 16'h0000;
		end else if (din == dout) begin
			cnt_reg <= 16'h0000;
		end else if (expired) begin
			dout <= din;
			cnt_reg <= 16'h0000;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end
endmodule

module trc_ain import trc_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic [10:0] raw,
	input wire trc_ain_cfg_s cfg,
	output logic signed [14:0] value
);
	logic signed [15:0] filt_reg;
	wire logic [10:0] volts = cfg.cur_mode ? {1'b0, raw[10:1]} : raw;
	wire logic [10:0] vclip = (volts > {1'b0, cfg.vmax}) ? {1'b0, cfg.vmax} : volts;
	wire logic below = vclip < {1'b0, cfg.vmin};
	wire logic signed [11:0] span_v = $signed({1'b0, vclip}) - $signed({2'b00, cfg.vmin});
	wire logic signed [11:0] range_v = $signed({2'b00, cfg.vmax}) - $signed({2'b00, cfg.vmin});
	wire logic signed [15:0] range_s = 16'(cfg.smax) - 16'(cfg.smin);
	wire logic signed [27:0] prod = 28'(span_v) * 28'(range_s);
	wire logic signed [27:0] quot = (range_v == 12'sh000) ? 28'sh0 : prod / 28'(range_v);
	wire logic signed [15:0] scaled = (range_v == 12'sh000) ? 16'(cfg.smax) :
		16'(cfg.smin) + 16'(quot);
	wire logic signed [15:0] target = below ? 16'(cfg.sbelow) : scaled;
	wire logic signed [16:0] diff = 17'(target) - 17'(filt_reg);
	// Integer division truncates, so the filter can settle up to ftime minus one counts short of the target.
	wire logic signed [16:0] step = (cfg.ftime == 10'h000) ? diff : diff / $signed({7'h00, cfg.ftime});
	always_ff @(posedge clk) begin
		if (rst) begin
			filt_reg <= 16'sh0000;
		end else if (tick) begin
			filt_reg <= filt_reg + 16'(step);
		end
	end
	assign value = 15'(filt_reg);
endmodule

module trc_decoder import trc_pkg::*; #(
	parameter int MS_CYC = MS_TICK_CYC,
	parameter logic [FREQ_W-1:0] FREQ_MAX = 32'h02faf080
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET,
	// Terminals, bit set while connected to common
	input wire logic [7:0] TERM_IN,
	// Terminal configuration
	input wire trc_mode_e MODE,
	input wire logic [4:0] POL_ONE,
	input wire logic [2:0] POL_TWO,
	input wire trc_dly_cfg_s DLY_CFG,
	// Up/down frequency adjustment
	input wire logic UP_CMD,
	input wire logic DOWN_CMD,
	input wire logic [15:0] UPDOWN_RATE,
	input wire logic [1:0] FREQ_RES,
	output logic [FREQ_W-1:0] FREQ_REF,
	// Analog inputs
	input wire logic [10:0] AIN1_RAW,
	input wire trc_ain_cfg_s AIN1_CFG,
	input wire logic [10:0] AIN2_RAW,
	input wire trc_ain_cfg_s AIN2_CFG,
	output logic signed [14:0] AIN1_VALUE,
	output logic signed [14:0] AIN2_VALUE,
	// Commands and conditioned terminal states
	output logic RUN_CMD,
	output logic REVERSE_CMD,
	output logic [7:0] TERM_ACTIVE
);
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	logic [$clog2(MS_CYC)-1:0] ms_cnt_reg;
	logic [6:0] dly_cnt_reg;
	logic [3:0] filt_cnt_reg;
	logic [2:0] prev_reg;
	// Each delay stage drives one bit, so this is a net rather than a variable.
	wire logic [2:0] cond;
	logic run_next;
	logic dir_next;

	// Time bases: one millisecond, then filter and delay steps.
	wire logic ms_tick = ms_cnt_reg == ($clog2(MS_CYC))'(MS_CYC - 1);
	wire logic dly_tick = ms_tick && (dly_cnt_reg == 7'(DLY_STEP_MS - 1));
	wire logic filt_tick = ms_tick && (filt_cnt_reg == 4'(FILT_STEP_MS - 1));
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			ms_cnt_reg <= '0;
			dly_cnt_reg <= 7'h00;
			filt_cnt_reg <= 4'h0;
		end else begin
			ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 1'b1;
			if (ms_tick) begin
				dly_cnt_reg <= dly_tick ? 7'h00 : dly_cnt_reg + 7'h01;
				filt_cnt_reg <= filt_tick ? 4'h0 : filt_cnt_reg + 4'h1;
			end
		end
	end

	// Two-stage synchroniser, then polarity; a set bit inverts the sense.
	wire logic [7:0] polarity = {POL_TWO, POL_ONE};
	wire logic [7:0] active = sync2_reg ^ polarity;
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
			TERM_ACTIVE <= 8'h00;
		end else begin
			sync1_reg <= TERM_IN;
			sync2_reg <= sync1_reg;
			TERM_ACTIVE <= {active[7:3], cond};
		end
	end

	trc_delay u_dly_fwd (.clk(SYS_CLK), .rst(RESET), .tick(dly_tick), .din(active[0]),
		.dly(DLY_CFG.forward_input), .dout(cond[0]));
	trc_delay u_dly_rev (.clk(SYS_CLK), .rst(RESET), .tick(dly_tick), .din(active[1]),
		.dly(DLY_CFG.reverse_input), .dout(cond[1]));
	trc_delay u_dly_third (.clk(SYS_CLK), .rst(RESET), .tick(dly_tick), .din(active[2]),
		.dly(DLY_CFG.third), .dout(cond[2]));

	wire logic forward_input = cond[0];
	wire logic reverse_input = cond[1];
	wire logic enable = cond[2];
	wire logic fwd_rise = forward_input && !prev_reg[0];
	wire logic rev_rise = reverse_input && !prev_reg[1];

	// Command decode; a stopped drive keeps its last direction.
	always_comb begin
		run_next = RUN_CMD;
		dir_next = REVERSE_CMD;
		unique case (MODE)
			MODE_TWO_A: begin
				run_next = forward_input ^ reverse_input;
				dir_next = (forward_input ^ reverse_input) ? reverse_input : REVERSE_CMD;
			end
			MODE_TWO_B: begin
				run_next = forward_input;
				dir_next = forward_input ? reverse_input : REVERSE_CMD;
			end
			MODE_THREE_A: begin
				// Simultaneous presses resolve to forward.
				if (!enable) begin
					run_next = 1'b0;
				end else if (fwd_rise) begin
					run_next = 1'b1;
					dir_next = 1'b0;
				end else if (rev_rise) begin
					run_next = 1'b1;
					dir_next = 1'b1;
				end
			end
			MODE_THREE_B: begin
				if (!enable) begin
					run_next = 1'b0;
				end else begin
					run_next = RUN_CMD || fwd_rise;
					dir_next = (RUN_CMD || fwd_rise) ? reverse_input : REVERSE_CMD;
				end
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			prev_reg <= 3'h0;
			RUN_CMD <= 1'b0;
			REVERSE_CMD <= 1'b0;
		end else begin
			prev_reg <= cond;
			RUN_CMD <= run_next;
			REVERSE_CMD <= dir_next;
		end
	end

	// Ramp: rate is mHz/s at fine resolution, tenfold at coarse; per ms that is uHz.
	wire logic [20:0] step = (FREQ_RES == RES_COARSE) ?
		21'(UPDOWN_RATE) * 21'(RATE_SCALE_COARSE) : 21'(UPDOWN_RATE);
	wire logic [FREQ_W:0] up_sum = {1'b0, FREQ_REF} + (FREQ_W + 1)'(step);
	wire logic at_top = up_sum > {1'b0, FREQ_MAX};
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			FREQ_REF <= '0;
		end else if (ms_tick && (UP_CMD != DOWN_CMD)) begin
			if (UP_CMD) begin
				FREQ_REF <= at_top ? FREQ_MAX : FREQ_W'(up_sum);
			end else begin
				FREQ_REF <= (FREQ_W'(step) > FREQ_REF) ? '0 : FREQ_REF - FREQ_W'(step);
			end
		end
	end

	trc_ain u_ain1 (.clk(SYS_CLK), .rst(RESET), .tick(filt_tick), .raw(AIN1_RAW),
		.cfg(AIN1_CFG), .value(AIN1_VALUE));
	trc_ain u_ain2 (.clk(SYS_CLK), .rst(RESET), .tick(filt_tick), .raw(AIN2_RAW),
		.cfg(AIN2_CFG), .value(AIN2_VALUE));

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);

	two_a_fwd_a: assert property (MODE == MODE_TWO_A && forward_input && !reverse_input |=> RUN_CMD && !REVERSE_CMD)
		else $error("two-wire one forward not run");
	two_a_stop_a: assert property (MODE == MODE_TWO_A && forward_input == reverse_input |=> !RUN_CMD)
		else $error("two-wire one did not stop");
	two_b_dir_a: assert property (MODE == MODE_TWO_B && forward_input |=> RUN_CMD && REVERSE_CMD == $past(reverse_input))
		else $error("two-wire two direction wrong");
	two_b_stop_a: assert property (MODE == MODE_TWO_B && !forward_input |=> !RUN_CMD)
		else $error("two-wire two did not stop");
	three_stop_a: assert property (MODE[1] && !enable |=> !RUN_CMD)
		else $error("three-wire did not stop on enable loss");
	three_a_start_a: assert property (MODE == MODE_THREE_A && enable && fwd_rise
		|=> RUN_CMD && !REVERSE_CMD)
		else $error("three-wire one forward press ignored");
	three_a_hold_a: assert property (MODE == MODE_THREE_A && enable && !fwd_rise && !rev_rise
		|=> $stable(RUN_CMD) && $stable(REVERSE_CMD))
		else $error("three-wire one state not latched");
	three_b_dir_a: assert property (MODE == MODE_THREE_B && enable && (fwd_rise || RUN_CMD)
		|=> RUN_CMD && REVERSE_CMD == $past(reverse_input))
		else $error("three-wire two run or direction wrong");
	ramp_up_a: assert property (ms_tick && UP_CMD && !DOWN_CMD && !at_top
		|=> FREQ_REF == $past(FREQ_REF) + FREQ_W'($past(step)))
		else $error("up ramp step wrong");
	ramp_idle_a: assert property (!ms_tick |=> $stable(FREQ_REF))
		else $error("frequency moved off tick");

	cover property (MODE == MODE_THREE_A && RUN_CMD && REVERSE_CMD);
	cover property (MODE == MODE_TWO_B && forward_input ##1 RUN_CMD);
	cover property (MODE == MODE_THREE_B && RUN_CMD ##1 !RUN_CMD);
	cover property (ms_tick && UP_CMD && at_top);
endmodule

/* trc_switches.sv */
// Model of the switches and push-buttons between the terminals and the common.
`timescale 1ns/10ps
module trc_switches (
	// Clock
	input wire logic clk,
	// Contacts closed by the bench
	input wire logic [7:0] closed,
	// Terminal levels, high while tied to common
	output logic [7:0] term
);
	// A contact settles one edge late, so the decoder never sees a same-edge change.
	always_ff @(posedge clk) begin
		term <= closed;
	end
endmodule

/* trc_decoder_tb.sv */
// Self-checking bench of the terminal run command decoder.
`timescale 1ns/10ps
module trc_decoder_tb import trc_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sw = 8'h00;
	logic [7:0] term_in;
	trc_mode_e mode = MODE_TWO_A;
	logic [4:0] pol_one = POL_ONE_RESET;
	logic [2:0] pol_two = POL_TWO_RESET;
	trc_dly_cfg_s dly = '0;
	logic up = 1'b0;
	logic down = 1'b0;
	logic [15:0] rate = 16'h000a;
	logic [1:0] res = 2'h0;
	logic [10:0] raw = 11'h000;
	trc_ain_cfg_s cfg = '{1'b0, 10'h064, 10'h384, 15'h0000, 15'h1f40, 15'h7e0c, 10'h000};
	logic [31:0] freq;
	logic [31:0] f0;
	logic signed [14:0] v1;
	logic signed [14:0] v2;
	logic run;
	logic reverse_input;
	logic [7:0] act;
	int fail_count = 0;
	int total_checks = 0;

	always #5 clk = ~clk;

	trc_switches sws (.clk(clk), .closed(sw), .term(term_in));
	trc_decoder #(.MS_CYC(20)) dut (.SYS_CLK(clk), .RESET(rst), .TERM_IN(term_in), .MODE(mode),
		.POL_ONE(pol_one), .POL_TWO(pol_two), .DLY_CFG(dly), .UP_CMD(up), .DOWN_CMD(down),
		.UPDOWN_RATE(rate), .FREQ_RES(res), .FREQ_REF(freq), .AIN1_RAW(raw), .AIN1_CFG(cfg),
		.AIN2_RAW(raw), .AIN2_CFG(cfg), .AIN1_VALUE(v1), .AIN2_VALUE(v2), .RUN_CMD(run),
		.REVERSE_CMD(reverse_input), .TERM_ACTIVE(act));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic step(input logic [7:0] v, input logic er, input logic erev);
		sw <= v;
		wait_cyc(8);
		check(32'(run), 32'(er));
		if (er) begin
			check(32'(reverse_input), 32'(erev));
		end
	endtask

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic t_wire();
		check({30'h0, run, reverse_input}, 32'h0);
		check(freq | 32'(act), 32'h0);
		step(8'h01, 1'b1, 1'b0);
		step(8'h03, 1'b0, 1'b0);
		step(8'h02, 1'b1, 1'b1);
		step(8'h00, 1'b0, 1'b0);
		mode <= MODE_TWO_B;
		step(8'h02, 1'b0, 1'b0);
		step(8'h03, 1'b1, 1'b1);
		step(8'h01, 1'b1, 1'b0);
		step(8'h00, 1'b0, 1'b0);
		$display("two-wire test done");
	endtask

	task automatic t_three();
		mode <= MODE_THREE_A;
		step(8'h04, 1'b0, 1'b0);
		step(8'h05, 1'b1, 1'b0);
		step(8'h04, 1'b1, 1'b0);
		step(8'h06, 1'b1, 1'b1);
		step(8'h04, 1'b1, 1'b1);
		step(8'h00, 1'b0, 1'b0);
		step(8'h04, 1'b0, 1'b0);
		mode <= MODE_THREE_B;
		step(8'h05, 1'b1, 1'b0);
		step(8'h04, 1'b1, 1'b0);
		step(8'h06, 1'b1, 1'b1);
		step(8'h04, 1'b1, 1'b0);
		step(8'h00, 1'b0, 1'b0);
		mode <= MODE_TWO_A;
		$display("three-wire test done");
	endtask

	task automatic t_levels();
		pol_one <= 5'h1f;
		pol_two <= 3'h7;
		step(8'h00, 1'b0, 1'b0);
		check(32'(act), 32'h000000ff);
		pol_one <= 5'h01;
		pol_two <= 3'h0;
		step(8'h00, 1'b1, 1'b0);
		pol_one <= 5'h00;
		step(8'hf8, 1'b0, 1'b0);
		check(32'(act), 32'h000000f8);
		dly.forward_input <= 16'h0001;
		step(8'h09, 1'b0, 1'b0);
		check(32'(act), 32'h00000008);
		wait_cyc(1890);
		check(32'(act[0]), 32'h0);
		wait_cyc(2200);
		check({30'h0, act[0], run}, 32'h3);
		sw <= 8'h00;
		wait_cyc(4200);
		dly.forward_input <= 16'h0000;
		$display("level and delay test done");
	endtask

	task automatic ramp(input logic u, input logic [1:0] r, input logic [31:0] exp);
		up <= u;
		down <= ~u;
		res <= r;
		wait_cyc(30);
		f0 = freq;
		wait_cyc(400);
		check(u ? freq - f0 : f0 - freq, exp);
	endtask

	task automatic ain(input logic [10:0] r, input logic cur, input logic [31:0] exp);
		raw <= r;
		cfg.cur_mode <= cur;
		wait_cyc(450);
		check(32'(v1), exp);
		check(32'(v2), exp);
	endtask

	task automatic t_numbers();
		ramp(1'b1, 2'h0, 32'h000000c8);
		ramp(1'b1, RES_COARSE, 32'h000007d0);
		ramp(1'b0, RES_COARSE, 32'h000007d0);
		wait_cyc(200);
		check(freq, 32'h0);
		down <= 1'b0;
		ain(11'h1f4, 1'b0, 32'h00000fa0);
		ain(11'h3e8, 1'b0, 32'h00001f40);
		ain(11'h032, 1'b0, 32'hfffffe0c);
		ain(11'h3e8, 1'b1, 32'h00000fa0);
		cfg.ftime <= 10'h3e8;
		raw <= 11'h3e8;
		cfg.cur_mode <= 1'b0;
		wait_cyc(250);
		check(32'((v1 > 15'sh0fa0) && (v1 < 15'sh1004)), 32'h1);
		$display("ramp and analog test done");
	endtask

	initial begin
		wait_cyc(100000);
		fail_count++;
		end_sim();
	end

	initial begin
		wait_cyc(16);
		rst <= 1'b0;
		wait_cyc(2);
		t_wire();
		t_three();
		t_levels();
		t_numbers();
		end_sim();
	end
endmodule
